/* File: gtc_timer.sv */
/*
 * gated 16-bit timer/event counter with axi4-lite registers and one
 * level interrupt on overflow.
 * assumes every pin input is asynchronous to aclk and slow compared
 * with it; a single aclk domain, synchronous active-low reset.
 */
`timescale 1ns/1ps
module gtc_timer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [gtc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [gtc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // count and gate sources
    input wire logic ext_count_clock_pin,
    input wire logic low_freq_internal_osc,
    input wire logic gate_input_pin,
    input wire logic comparator_one,
    input wire logic comparator_two,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] sync;
        logic [4:0] prev;
        logic [1:0] phase;
        logic [2:0] pre;
        logic armed;
        logic pend;
        logic [7:0] ctrl;
        logic [7:0] gate;
        logic ovf_stat;
        logic ovf_en;
        logic aw_full;
        logic w_full;
        logic [gtc_pkg::ADDR_W-1:0] aw_addr;
        logic [7:0] w_byte;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic irq;
    } gtc_main_state_t;
    gtc_main_state_t s;
    gtc_main_state_t next_s;
    gtc_cnt_if cif ();
    gtc_pkg::gtc_src_t src;
    logic on;
    logic tick;
    logic gate_lvl;
    logic gate_open;
    logic run;
    logic ext_rise;
    logic ext_hit;
    logic src_evt;
    logic [2:0] pre_mask;
    logic do_wr;
    logic wr_cnt;
    logic clr_ovf;
    //======================================================================
    // count register
    gtc_count_core u_core (
        .aclk(aclk),
        .aresetn(aresetn),
        .cif(cif)
    );
    //======================================================================
    // decode of control bits and gate
    always_comb begin
        on = s.ctrl[gtc_pkg::CTRL_ON];
        src = gtc_pkg::gtc_src_t'(s.ctrl[gtc_pkg::CTRL_SRC +: 2]);
        tick = s.phase == gtc_pkg::PHASE_LAST;
        case (s.gate[gtc_pkg::GATE_SRC +: 2])
            2'h1: gate_lvl = s.sync[gtc_pkg::IN_CMP1];
            2'h2: gate_lvl = s.sync[gtc_pkg::IN_CMP2];
            default: gate_lvl = s.sync[gtc_pkg::IN_GATE];
        endcase
        gate_open = gate_lvl == s.gate[gtc_pkg::GATE_POL];
        run = on && (!s.gate[gtc_pkg::GATE_EN] || gate_open);
        ext_rise = gtc_pkg::gtc_rise(s.prev[gtc_pkg::IN_EXT],
            s.sync[gtc_pkg::IN_EXT]);
        ext_hit = ext_rise && s.armed;
        case (src)
            gtc_pkg::GTC_SRC_INSTR: src_evt = tick;
            gtc_pkg::GTC_SRC_SYS: src_evt = 1'b1;
            gtc_pkg::GTC_SRC_LFO: src_evt = gtc_pkg::gtc_rise(
                s.prev[gtc_pkg::IN_LFO], s.sync[gtc_pkg::IN_LFO]);
            gtc_pkg::GTC_SRC_EXT: begin
                if (s.ctrl[gtc_pkg::CTRL_ASYNC]) src_evt = ext_hit;
                else src_evt = tick && (s.pend || ext_hit);
            end
            default: src_evt = 1'b0;
        endcase
        case (s.ctrl[gtc_pkg::CTRL_PRE +: 2])
            2'h0: pre_mask = 3'h0;
            2'h1: pre_mask = 3'h1;
            2'h2: pre_mask = 3'h3;
            default: pre_mask = 3'h7;
        endcase
    end
    //======================================================================
    // bus write decode, done once both address and data are held
    always_comb begin
        do_wr = s.aw_full && s.w_full && !s.bvalid;
        wr_cnt = do_wr && s.w_lane0 && (s.aw_addr == gtc_pkg::ADDR_CLO
            || s.aw_addr == gtc_pkg::ADDR_CHI);
        clr_ovf = do_wr && s.w_lane0 && s.aw_addr == gtc_pkg::ADDR_CLR
            && s.w_byte[gtc_pkg::STAT_OVF];
        cif.load_lo = wr_cnt && s.aw_addr == gtc_pkg::ADDR_CLO;
        cif.load_hi = wr_cnt && s.aw_addr == gtc_pkg::ADDR_CHI;
        cif.wdata = s.w_byte;
        cif.inc = run && src_evt && ((s.pre & pre_mask) == pre_mask)
            && !wr_cnt;
    end
    //======================================================================
    // next state
    always_comb begin
        next_s = s;
        // two-stage synchronisers, then the edge history
        next_s.meta = {comparator_two, comparator_one, gate_input_pin,
            low_freq_internal_osc, ext_count_clock_pin};
        next_s.sync = s.meta;
        next_s.prev = s.sync;
        next_s.phase = s.phase + 2'h1;
        // prescaler steps on each gated source event
        if (!on || wr_cnt) next_s.pre = 3'h0;
        else if (run && src_evt) begin
            if ((s.pre & pre_mask) == pre_mask) next_s.pre = 3'h0;
            else next_s.pre = s.pre + 3'h1;
        end
        // a falling edge arms the external input again
        if (!on || wr_cnt) next_s.armed = 1'b0;
        else if (gtc_pkg::gtc_rise(s.sync[gtc_pkg::IN_EXT],
            s.prev[gtc_pkg::IN_EXT])) next_s.armed = 1'b1;
        next_s.pend = on && !wr_cnt && !s.ctrl[gtc_pkg::CTRL_ASYNC]
            && src == gtc_pkg::GTC_SRC_EXT && !tick
            && (s.pend || ext_hit);
        // overflow flag, set wins over clear
        next_s.ovf_stat = (s.ovf_stat && !clr_ovf) || cif.wrap;
        // write address and data channels, taken in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.w_byte = s_axi_wdata[7:0];
            next_s.w_lane0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
        if (do_wr) begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = gtc_pkg::RESP_OKAY;
            case (s.aw_addr)
                gtc_pkg::ADDR_CTRL: begin
                    if (s.w_lane0)
                        next_s.ctrl = s.w_byte & gtc_pkg::CTRL_MASK;
                end
                gtc_pkg::ADDR_GATE: begin
                    if (s.w_lane0)
                        next_s.gate = s.w_byte & gtc_pkg::GATE_MASK;
                end
                gtc_pkg::ADDR_IEN: begin
                    if (s.w_lane0)
                        next_s.ovf_en = s.w_byte[gtc_pkg::STAT_OVF];
                end
                gtc_pkg::ADDR_CLO, gtc_pkg::ADDR_CHI, gtc_pkg::ADDR_STAT,
                gtc_pkg::ADDR_CLR: next_s.bresp = gtc_pkg::RESP_OKAY;
                default: next_s.bresp = gtc_pkg::RESP_SLVERR;
            endcase
        end
        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready = !next_s.w_full && !next_s.bvalid;
        // read channel, one answer per address
        if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = gtc_pkg::RESP_OKAY;
            next_s.rdata = 32'h0;
            case (s_axi_araddr)
                gtc_pkg::ADDR_CTRL: next_s.rdata[7:0] = s.ctrl;
                gtc_pkg::ADDR_GATE: next_s.rdata[7:0] = s.gate;
                gtc_pkg::ADDR_CLO: next_s.rdata[7:0] = cif.count[7:0];
                gtc_pkg::ADDR_CHI: next_s.rdata[7:0] = cif.count[15:8];
                gtc_pkg::ADDR_STAT:
                    next_s.rdata[gtc_pkg::STAT_OVF] = s.ovf_stat;
                gtc_pkg::ADDR_IEN:
                    next_s.rdata[gtc_pkg::STAT_OVF] = s.ovf_en;
                gtc_pkg::ADDR_CLR: next_s.rresp = gtc_pkg::RESP_OKAY;
                default: next_s.rresp = gtc_pkg::RESP_SLVERR;
            endcase
        end
        next_s.arready = !next_s.rvalid;
        next_s.irq = next_s.ovf_stat && next_s.ovf_en;
    end
    //======================================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.ctrl <= gtc_pkg::CTRL_RST;
            s.gate <= gtc_pkg::GATE_RST;
        end else begin
            s <= next_s;
        end
    end
    //======================================================================
    // outputs
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign irq = s.irq;
    //======================================================================
    // checks
    off_holds_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !on && !cif.load_lo && !cif.load_hi |=> $stable(cif.count))
        else $error("count moved while counter off");
    sys_rate_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        on && !s.gate[gtc_pkg::GATE_EN] && src == gtc_pkg::GTC_SRC_SYS
        && s.ctrl[gtc_pkg::CTRL_PRE +: 2] == 2'h0 && !wr_cnt
        |=> cif.count == 16'($past(cif.count) + 16'h1))
        else $error("system clock source missed an increment");
    instr_rate_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        run && src == gtc_pkg::GTC_SRC_INSTR && !wr_cnt
        && s.ctrl[gtc_pkg::CTRL_PRE +: 2] == 2'h0 |-> cif.inc == tick)
        else $error("instruction source not once per cycle");
    ext_edge_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cif.inc && src == gtc_pkg::GTC_SRC_EXT && s.ctrl[gtc_pkg::CTRL_ASYNC]
        |-> s.armed && ext_rise)
        else $error("external count without armed rising edge");
    gate_shut_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.gate[gtc_pkg::GATE_EN] && !gate_open |-> !cif.inc)
        else $error("count advanced while gate closed");
    rearm_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_cnt || !on |=> !s.armed ##1 (!s.armed || !cif.inc))
        else $error("external input not disarmed");
    sync_tick_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cif.inc && src == gtc_pkg::GTC_SRC_EXT
        && !s.ctrl[gtc_pkg::CTRL_ASYNC] |-> tick)
        else $error("synchronised external count off cycle");
    ovf_irq_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cif.wrap && s.ovf_en |=> irq && s.ovf_stat)
        else $error("overflow did not raise interrupt");
    // set beats clear, so the clear check leaves out a wrap in that cycle
    ovf_clear_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        clr_ovf && !cif.wrap |=> !s.ovf_stat)
        else $error("overflow flag not cleared");
    ovf_sticky_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s.ovf_stat && !clr_ovf |=> s.ovf_stat)
        else $error("overflow flag dropped without a clear");
    irq_level_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        irq == (s.ovf_stat && s.ovf_en))
        else $error("interrupt level disagrees with flag and enable");
    slow_edge_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cif.inc && src == gtc_pkg::GTC_SRC_LFO
        |-> s.sync[gtc_pkg::IN_LFO] && !s.prev[gtc_pkg::IN_LFO])
        else $error("slow oscillator count without a rising edge");
    ext_count_c: cover property (@(posedge aclk) disable iff (!aresetn)
        cif.inc && src == gtc_pkg::GTC_SRC_EXT);
    gated_count_c: cover property (@(posedge aclk) disable iff (!aresetn)
        cif.inc && s.gate[gtc_pkg::GATE_EN]);
    irq_c: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule : gtc_timer

/* File: gtc_pkg.sv */
/*
 * constants, field layout and types of the gated 16-bit counter.
 * assumes an axi4-lite register slave on a single 40 mhz clock.
 */
//==========================================================================
package gtc_pkg;
    //======================================================================
    // register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_GATE = 5'h04;
    localparam logic [4:0] ADDR_CLO = 5'h08;
    localparam logic [4:0] ADDR_CHI = 5'h0c;
    localparam logic [4:0] ADDR_STAT = 5'h10;
    localparam logic [4:0] ADDR_CLR = 5'h14;
    localparam logic [4:0] ADDR_IEN = 5'h18;
    //======================================================================
    // field positions and reset values
    localparam int CTRL_ON = 0;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_ASYNC = 3;
    localparam int CTRL_PRE = 4;
    localparam logic [7:0] CTRL_MASK = 8'h3f;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int GATE_EN = 0;
    localparam int GATE_POL = 1;
    localparam int GATE_SRC = 2;
    localparam logic [7:0] GATE_MASK = 8'h0f;
    localparam logic [7:0] GATE_RST = 8'h02;
    localparam int STAT_OVF = 0;
    //======================================================================
    // synchroniser lanes
    localparam int IN_EXT = 0;
    localparam int IN_LFO = 1;
    localparam int IN_GATE = 2;
    localparam int IN_CMP1 = 3;
    localparam int IN_CMP2 = 4;
    //======================================================================
    // timing and bus answers
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        GTC_SRC_INSTR = 2'h0,
        GTC_SRC_SYS = 2'h1,
        GTC_SRC_EXT = 2'h2,
        GTC_SRC_LFO = 2'h3
    } gtc_src_t;
    // rising edge of a synchronised level
    function automatic logic gtc_rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction : gtc_rise
endpackage : gtc_pkg

/* File: gtc_cnt_if.sv */
/*
 * bundle between the counter control logic and the count register.
 * assumes both ends run on aclk.
 */
`timescale 1ns/1ps
interface gtc_cnt_if;
    logic inc;
    logic load_lo;
    logic load_hi;
    logic [7:0] wdata;
    logic [15:0] count;
    logic wrap;
    modport ctl (output inc, output load_lo, output load_hi,
        output wdata, input count, input wrap);
    modport core (input inc, input load_lo, input load_hi,
        input wdata, output count, output wrap);
endinterface : gtc_cnt_if

/* File: gtc_count_core.sv */
/*
 * the 16-bit count register with byte loads and wrap pulse.
 * assumes loads and increments come from logic on aclk.
 */
`timescale 1ns/1ps
module gtc_count_core (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control side
    gtc_cnt_if.core cif
);
    typedef struct packed {
        logic [15:0] count;
        logic wrap;
    } gtc_core_state_t;
    gtc_core_state_t s;
    gtc_core_state_t next_s;
    //======================================================================
    // count update: byte writes win over the increment
    always_comb begin
        next_s = s;
        next_s.wrap = 1'b0;
        if (cif.load_lo || cif.load_hi) begin
            if (cif.load_lo) next_s.count[7:0] = cif.wdata;
            if (cif.load_hi) next_s.count[15:8] = cif.wdata;
        end else if (cif.inc) begin
            next_s.count = s.count + 16'h1;
            next_s.wrap = s.count == 16'hffff;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) s <= '0;
        else s <= next_s;
    end
    assign cif.count = s.count;
    assign cif.wrap = s.wrap;
    //======================================================================
    // checks
    load_low_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cif.load_lo && !cif.load_hi |=> s.count[7:0] == $past(cif.wdata)
        && s.count[15:8] == $past(s.count[15:8]))
        else $error("low byte write not applied");
    wrap_zero_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        cif.inc && !cif.load_lo && !cif.load_hi && s.count == 16'hffff
        |=> s.count == 16'h0 && s.wrap)
        else $error("all-ones increment did not wrap");
    up_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !cif.load_lo && !cif.load_hi && !cif.inc |=> $stable(s.count))
        else $error("count moved without increment or write");
    wrap_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
        s.wrap);
endmodule : gtc_count_core

/* File: gtc_src_model.sv */
/*
 * partner model of the pins around the counter: external count clock,
 * slow oscillator, gate pin and the two comparator outputs.
 * assumes the bench calls its tasks from code timed by aclk.
 */
`timescale 1ns/1ps
module gtc_src_model (
    // clock
    input wire logic aclk,
    // source pins
    output logic ext_pin,
    output logic lfo,
    output logic gate_pin,
    output logic cmp_one,
    output logic cmp_two
);
    logic [4:0] lvl = 5'h00;
    // one lane per pin, numbered as the synchroniser lanes
    assign ext_pin = lvl[gtc_pkg::IN_EXT];
    assign lfo = lvl[gtc_pkg::IN_LFO];
    assign gate_pin = lvl[gtc_pkg::IN_GATE];
    assign cmp_one = lvl[gtc_pkg::IN_CMP1];
    assign cmp_two = lvl[gtc_pkg::IN_CMP2];
    // hold one pin at a level, changed just after an edge
    task automatic drive(input int sel, input logic v);
        @(posedge aclk);
        lvl[sel] <= v;
    endtask : drive
    // whole pulses, each with a full low phase; pin idles low after
    task automatic pulse(input int sel, input int n, input int half);
        for (int i = 0; i < n; i++) begin
            drive(sel, 1'b1);
            repeat (half) @(posedge aclk);
            drive(sel, 1'b0);
            repeat (half) @(posedge aclk);
        end
    endtask : pulse
endmodule : gtc_src_model

/* File: gtc_timer_tb.sv */
/*
 * self-checking bench of the gated counter over axi4-lite.
 * assumes gtc_pkg, the design and gtc_src_model are compiled first.
 */
`timescale 1ns/1ps
module gtc_timer_tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic ext_pin, lfo, gate_pin, cmp_one, cmp_two;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int c1, c2, n, lane;
    logic [7:0] ctl, b;
    logic [4:0] ra [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
    logic [7:0] rv [7] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    //======================================================================
    // design and partner
    gtc_timer u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_count_clock_pin(ext_pin), .low_freq_internal_osc(lfo),
        .gate_input_pin(gate_pin), .comparator_one(cmp_one),
        .comparator_two(cmp_two), .irq(irq));
    gtc_src_model u_src (.aclk(aclk), .ext_pin(ext_pin), .lfo(lfo),
        .gate_pin(gate_pin), .cmp_one(cmp_one), .cmp_two(cmp_two));
    //======================================================================
    // clock and hang limit
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            conclude();
        end
    end
    //======================================================================
    // checks, verdict and bus cycles
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // write one word; the response code lands in rsp
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'h1);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                rsp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr
    // read one word into rd and rsp
    task automatic rdr(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                rsp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : rdr
    task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
        rdr(a);
        check("read data", rd, {24'h0, e});
        check("read resp", {30'h0, rsp}, {30'h0, gtc_pkg::RESP_OKAY});
    endtask : chk_rd
    // live count from both bytes
    task automatic cnt(output int c);
        rdr(gtc_pkg::ADDR_CLO);
        c = int'(rd[7:0]);
        rdr(gtc_pkg::ADDR_CHI);
        c = c + 256 * int'(rd[7:0]);
    endtask : cnt
    // stop, zero the count, start with a new control value
    task automatic restart(input logic [7:0] k);
        wr(gtc_pkg::ADDR_CTRL, 32'h0);
        wr(gtc_pkg::ADDR_CLO, 32'h0);
        wr(gtc_pkg::ADDR_CHI, 32'h0);
        wr(gtc_pkg::ADDR_CTRL, {24'h0, k});
    endtask : restart
    task automatic measure(input logic [7:0] k, input int w, output int c);
        restart(k);
        repeat (w) @(posedge aclk);
        wr(gtc_pkg::ADDR_CTRL, 32'h0);
        cnt(c);
    endtask : measure
    // counts gained between a 20 and a 100 cycle run, within one count
    task automatic span(input logic [7:0] k, input real ideal);
        measure(k, 20, c1);
        measure(k, 100, c2);
        check("count span", {31'h0, ($itor(c2 - c1) - ideal) ** 2 <= 1.0},
            32'h1);
    endtask : span
    //======================================================================
    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        n = $urandom(32'hb253);
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check("irq after reset", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 7; i++) chk_rd(ra[i], rv[i]);
        rdr(5'h1c);
        check("unmapped data", rd, 32'h0);
        check("unmapped rresp", {30'h0, rsp}, 32'h2);
        wr(5'h1c, 32'hff);
        check("unmapped bresp", {30'h0, rsp}, 32'h2);
        wr(gtc_pkg::ADDR_CTRL, 32'hff);
        chk_rd(gtc_pkg::ADDR_CTRL, gtc_pkg::CTRL_MASK);
        wr(gtc_pkg::ADDR_GATE, 32'hff);
        chk_rd(gtc_pkg::ADDR_GATE, gtc_pkg::GATE_MASK);
        // random byte loads; a write without strobe leaves the byte
        for (int i = 0; i < 2; i++) begin
            b = 8'($urandom_range(255));
            wr(i ? gtc_pkg::ADDR_CHI : gtc_pkg::ADDR_CLO, {24'h0, b});
            wr(i ? gtc_pkg::ADDR_CHI : gtc_pkg::ADDR_CLO, {24'h0, ~b}, 4'h0);
            chk_rd(i ? gtc_pkg::ADDR_CHI : gtc_pkg::ADDR_CLO, b);
        end
        // on bit clear stops counting whatever the gate enable holds
        for (int g = 0; g < 2; g++) begin
            wr(gtc_pkg::ADDR_GATE, 32'h2 | g);
            measure(8'h02, 60, c1);
            check("off count", 32'(c1), 32'h0);
        end
        // free running again: the last pass left the gate enabled and shut
        wr(gtc_pkg::ADDR_GATE, {24'h0, gtc_pkg::GATE_RST});
        // instruction and system clock sources at every prescale
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 4; p++) begin
                span(8'(p << 4 | s << 1 | 1), 80.0 / (2 ** p) / (s ? 1 : 4));
            end
        end
        // gate sources and polarity: open counts, closed holds
        for (int g = 0; g < 8; g++) begin
            lane = (g >> 1) == 3 ? gtc_pkg::IN_GATE : gtc_pkg::IN_GATE + g / 2;
            for (int j = 2; j < 5; j++) u_src.drive(j, ~g[0]);
            u_src.drive(lane, g[0]);
            wr(gtc_pkg::ADDR_GATE, 32'(g << 1 | 1));
            span(8'h03, 80.0);
            for (int j = 2; j < 5; j++) u_src.drive(j, g[0]);
            u_src.drive(lane, ~g[0]);
            measure(8'h03, 40, c1);
            check("closed gate", 32'(c1), 32'h0);
        end
        wr(gtc_pkg::ADDR_GATE, {24'h0, gtc_pkg::GATE_RST});
        // external pin, aligned and raw: first rise needs a fall first
        for (int a = 0; a < 2; a++) begin
            ctl = 8'(a << 3 | 5);
            n = 3 + $urandom_range(4);
            restart(ctl);
            u_src.pulse(gtc_pkg::IN_EXT, n, 8);
            cnt(c1);
            check("ext after enable", 32'(c1), 32'(n - 1));
            wr(gtc_pkg::ADDR_CLO, 32'h0);
            u_src.pulse(gtc_pkg::IN_EXT, n, 8);
            cnt(c1);
            check("ext after load", 32'(c1), 32'(n - 1));
            u_src.drive(gtc_pkg::IN_EXT, 1'b1);
            repeat (8) @(posedge aclk);
            wr(gtc_pkg::ADDR_CTRL, 32'h0);
            u_src.drive(gtc_pkg::IN_EXT, 1'b0);
            wr(gtc_pkg::ADDR_CTRL, {24'h0, ctl});
            u_src.pulse(gtc_pkg::IN_EXT, n, 8);
            cnt(c1);
            check("ext re-enable", 32'(c1), 32'(2 * n - 1));
        end
        // slow oscillator counts its rising edges
        restart(8'h07);
        u_src.pulse(gtc_pkg::IN_LFO, n, 6);
        cnt(c1);
        check("slow osc count", 32'(c1), 32'(n));
        // wrap from all ones: sticky flag, masked, enabled, cleared
        wr(gtc_pkg::ADDR_CTRL, 32'h0);
        wr(gtc_pkg::ADDR_CLO, 32'hff);
        wr(gtc_pkg::ADDR_CHI, 32'hff);
        wr(gtc_pkg::ADDR_CTRL, 32'h3);
        repeat (20) @(posedge aclk);
        wr(gtc_pkg::ADDR_CTRL, 32'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        chk_rd(gtc_pkg::ADDR_STAT, 8'h01);
        chk_rd(gtc_pkg::ADDR_CHI, 8'h00);
        wr(gtc_pkg::ADDR_IEN, 32'h1);
        repeat (3) @(posedge aclk);
        check("irq enabled", {31'h0, irq}, 32'h1);
        wr(gtc_pkg::ADDR_CLR, 32'h1);
        repeat (3) @(posedge aclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        chk_rd(gtc_pkg::ADDR_STAT, 8'h00);
        chk_rd(gtc_pkg::ADDR_CLR, 8'h00);
        conclude();
    end
endmodule : gtc_timer_tb
